// [inc/cpu_core_consts.svh]
`ifndef CPU_CORE_CONSTS_SVH
`define CPU_CORE_CONSTS_SVH

// ****************************************
// special function register addresses
// ****************************************
`define SFR_STACK_POINTER   8'h81
`define SFR_POINTER_LOW     8'h82
`define SFR_POINTER_HIGH    8'h83
`define SFR_POINTER_AUX     8'hA2
`define SFR_STATUS_WORD     8'hD0
`define SFR_MAIN_OPERAND    8'hE0
`define SFR_MUL_DIV_AUX     8'hF0

// ****************************************
// reset values
// ****************************************
`define RST_STACK_POINTER   8'h07
`define RST_STATUS_WORD     8'h00
`define RST_MAIN_OPERAND    8'h00
`define RST_MUL_DIV_AUX     8'h00
`define RST_POINTER         16'h0000
`define AUX_UNUSED_READ     8'h00

// ****************************************
// status word field positions
// ****************************************
`define PSW_CARRY           7
`define PSW_HALF_CARRY      6
`define PSW_USER_ZERO       5
`define PSW_BANK_HIGH       4
`define PSW_BANK_LOW        3
`define PSW_SIGNED_WRAP     2
`define PSW_USER_ONE        1
`define PSW_PARITY          0

// ****************************************
// pointer aux field positions
// ****************************************
`define AUX_GENERAL_TWO     3
`define AUX_POINTER_SELECT  0

`endif

// [inc/cpu_core_pkg.sv]
package cpu_core_pkg;

    // arithmetic operation applied to the main operand
    typedef enum logic [2:0] {
        ALU_NONE = 3'h0,
        ALU_ADD  = 3'h1,
        ALU_ADDC = 3'h2,
        ALU_SUBB = 3'h3,
        ALU_MUL  = 3'h4,
        ALU_DIV  = 3'h5
    } alu_op_e;

    // boolean operation with the carry flag as destination
    typedef enum logic [2:0] {
        BOOL_NONE = 3'h0,
        BOOL_CLR  = 3'h1,
        BOOL_SET  = 3'h2,
        BOOL_CPL  = 3'h3,
        BOOL_ANL  = 3'h4,
        BOOL_ORL  = 3'h5,
        BOOL_ANLN = 3'h6,
        BOOL_MOV  = 3'h7
    } bool_op_e;

endpackage

// [inc/ptr_bank_if.sv]
interface ptr_bank_if;
    logic        aux_wr;
    logic        aux_toggle;
    logic [7:0]  aux_wdata;
    logic        lo_wr;
    logic        hi_wr;
    logic [7:0]  byte_wdata;
    logic        load16;
    logic        inc16;
    logic [15:0] load_val;
    logic [7:0]  lo;
    logic [7:0]  hi;
    logic [7:0]  aux_rd;
    logic [15:0] ptr_active;

    modport ctrl (output aux_wr, aux_toggle, aux_wdata, lo_wr, hi_wr, byte_wdata,
                  output load16, inc16, load_val, input lo, hi, aux_rd, ptr_active);
    modport bank (input aux_wr, aux_toggle, aux_wdata, lo_wr, hi_wr, byte_wdata,
                  input load16, inc16, load_val, output lo, hi, aux_rd, ptr_active);
endinterface

// [hw/data_pointer_bank.sv]
`include "cpu_core_consts.svh"

module data_pointer_bank #(
    parameter int NUM_PTR = 2
) (
    input  wire logic  ref_clk,
    input  wire logic  rst_n,
    input  wire logic  clk_en,
    ptr_bank_if.bank   pb
);

    logic [15:0] ptr_reg    [NUM_PTR];
    logic [15:0] ptr_next   [NUM_PTR];
    logic        select_reg;
    logic        select_next;
    logic        gen_flag_reg;
    logic [15:0] active_reg;

    // ****************************************
    // pointer select and general flag
    // ****************************************
    // toggle on increment, plain store on write
    always_comb begin
        select_next = select_reg;
        if (pb.aux_wr) begin
            select_next = pb.aux_wdata[`AUX_POINTER_SELECT];
        end else if (pb.aux_toggle) begin
            select_next = ~select_reg;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            select_reg   <= 1'b0;
            gen_flag_reg <= 1'b0;
        end else if (clk_en) begin
            select_reg <= select_next;
            if (pb.aux_wr) begin
                gen_flag_reg <= pb.aux_wdata[`AUX_GENERAL_TWO];
            end
        end
    end

    // ****************************************
    // pointer storage
    // ****************************************
    // only the selected pointer takes byte, word or increment updates
    for (genvar i = 0; i < NUM_PTR; i++) begin : g_ptr
        always_comb begin
            ptr_next[i] = ptr_reg[i];
            if (select_reg == i[0]) begin
                if (pb.load16) begin
                    ptr_next[i] = pb.load_val;
                end else if (pb.inc16) begin
                    ptr_next[i] = ptr_reg[i] + 16'h0001;
                end else begin
                    if (pb.lo_wr) begin
                        ptr_next[i][7:0] = pb.byte_wdata;
                    end
                    if (pb.hi_wr) begin
                        ptr_next[i][15:8] = pb.byte_wdata;
                    end
                end
            end
        end

        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                ptr_reg[i] <= `RST_POINTER;
            end else if (clk_en) begin
                ptr_reg[i] <= ptr_next[i];
            end
        end
    end

    // registered copy of the pointer the next cycle will use
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            active_reg <= `RST_POINTER;
        end else if (clk_en) begin
            active_reg <= ptr_next[select_next];
        end
    end

    // ****************************************
    // read side
    // ****************************************
    assign pb.lo         = ptr_reg[select_reg][7:0];
    assign pb.hi         = ptr_reg[select_reg][15:8];
    assign pb.ptr_active = active_reg;
    // unused bits read as a fixed constant
    always_comb begin
        pb.aux_rd = `AUX_UNUSED_READ;
        pb.aux_rd[`AUX_GENERAL_TWO]    = gen_flag_reg;
        pb.aux_rd[`AUX_POINTER_SELECT] = select_reg;
    end

endmodule

// [hw/cpu_core_status_and_pointers.sv]
// Overview of operation
// - stack pointer is eight bits wide
// - push increments pointer, then writes RAM
// - stack pointer resets to 07H
// - stack wraps across all 256 RAM bytes
// - status word layout at D0H, resets zero
// - carry set on carry, borrow or boolean ops
// - half carry set on nibble carry/borrow
// - carry is the boolean accumulator
// - bank bits choose R0-R7 RAM base
// - overflow on signed wrap, big product, zero divide
// - parity follows odd count of accumulator ones
// - user flags just store written values
// - pointer usable as word or two bytes
// - two pointers share one address
// - select 0 primary, 1 secondary pointer
// - aux bit 3 general flag, reset 0xx0
// - accumulator at E0H, resets zero
// - helper at F0H, multiply/divide operand
`include "cpu_core_consts.svh"

module cpu_core_status_and_pointers (
    input  wire logic                   ref_clk,
    input  wire logic                   rst_n,
    input  wire logic                   clk_en,
    input  wire logic [7:0]             sfr_addr,
    input  wire logic                   sfr_wr,
    input  wire logic                   sfr_inc,
    input  wire logic [7:0]             sfr_wdata,
    input  wire logic                   sfr_rd,
    output logic      [7:0]             sfr_rdata,
    output logic                        sfr_hit,
    input  wire cpu_core_pkg::alu_op_e  alu_op,
    input  wire logic [7:0]             alu_operand,
    input  wire cpu_core_pkg::bool_op_e bool_op,
    input  wire logic                   bool_bit,
    input  wire logic                   push_req,
    input  wire logic [7:0]             push_data,
    input  wire logic                   pop_req,
    input  wire logic                   ptr_load,
    input  wire logic [15:0]            ptr_load_val,
    input  wire logic                   ptr_inc,
    output logic                        ram_wr_en,
    output logic      [7:0]             ram_addr,
    output logic      [7:0]             ram_wdata,
    output logic      [7:0]             stack_pointer,
    output logic      [7:0]             cpu_status_word,
    output logic      [7:0]             main_operand_reg,
    output logic      [7:0]             mul_div_aux,
    output logic      [4:0]             bank_base,
    output logic      [15:0]            data_pointer_pair
);

    // ****************************************
    // declarations
    // ****************************************
    logic [7:0]  acc_reg;
    logic [7:0]  acc_next;
    logic [7:0]  b_reg;
    logic [7:0]  b_next;
    logic [7:0]  psw_reg;
    logic [7:0]  psw_next;
    logic        parity_reg;
    logic [7:0]  sp_reg;
    logic [7:0]  sp_next;
    logic [7:0]  alu_acc;
    logic [7:0]  alu_b;
    logic        alu_cy;
    logic        alu_ac;
    logic        alu_ov;
    logic        alu_acc_wr;
    logic        alu_b_wr;
    logic        alu_ac_wr;
    logic        bool_cy;
    logic [8:0]  sum9;
    logic [4:0]  sum5;
    logic [15:0] product;
    logic        cin;
    logic [7:0]  rd_value;
    logic        rd_mapped;
    logic [7:0]  psw_view;

    ptr_bank_if pb ();

    // ****************************************
    // address decode helper
    // ****************************************
    // true when an access targets the given register
    function automatic logic at_addr(input logic [7:0] addr, input logic [7:0] target);
        at_addr = (addr == target);
    endfunction

    // ****************************************
    // arithmetic unit
    // ****************************************
    // flags for add, add with carry, subtract with borrow, multiply, divide
    always_comb begin
        alu_acc    = acc_reg;
        alu_b      = b_reg;
        alu_cy     = psw_reg[`PSW_CARRY];
        alu_ac     = psw_reg[`PSW_HALF_CARRY];
        alu_ov     = psw_reg[`PSW_SIGNED_WRAP];
        alu_acc_wr = 1'b0;
        alu_b_wr   = 1'b0;
        alu_ac_wr  = 1'b0;
        sum9       = 9'h000;
        sum5       = 5'h00;
        product    = 16'h0000;
        cin        = (alu_op == cpu_core_pkg::ALU_ADD) ? 1'b0 : psw_reg[`PSW_CARRY];
        case (alu_op)
            cpu_core_pkg::ALU_ADD, cpu_core_pkg::ALU_ADDC: begin
                sum9       = {1'b0, acc_reg} + {1'b0, alu_operand} + {8'h00, cin};
                sum5       = {1'b0, acc_reg[3:0]} + {1'b0, alu_operand[3:0]} + {4'h0, cin};
                alu_acc    = sum9[7:0];
                alu_cy     = sum9[8];
                alu_ac     = sum5[4];
                alu_ov     = (acc_reg[7] == alu_operand[7]) &&
                             (sum9[7] != acc_reg[7]);
                alu_acc_wr = 1'b1;
                alu_ac_wr  = 1'b1;
            end
            cpu_core_pkg::ALU_SUBB: begin
                sum9       = {1'b0, acc_reg} - {1'b0, alu_operand} - {8'h00, cin};
                sum5       = {1'b0, acc_reg[3:0]} - {1'b0, alu_operand[3:0]} - {4'h0, cin};
                alu_acc    = sum9[7:0];
                alu_cy     = sum9[8];
                alu_ac     = sum5[4];
                alu_ov     = (acc_reg[7] != alu_operand[7]) &&
                             (sum9[7] != acc_reg[7]);
                alu_acc_wr = 1'b1;
                alu_ac_wr  = 1'b1;
            end
            cpu_core_pkg::ALU_MUL: begin
                product    = {8'h00, acc_reg} * {8'h00, b_reg};
                alu_acc    = product[7:0];
                alu_b      = product[15:8];
                alu_cy     = 1'b0;
                alu_ov     = (product[15:8] != 8'h00);
                alu_acc_wr = 1'b1;
                alu_b_wr   = 1'b1;
            end
            cpu_core_pkg::ALU_DIV: begin
                alu_cy = 1'b0;
                if (b_reg == 8'h00) begin
                    alu_ov = 1'b1;
                end else begin
                    alu_acc    = acc_reg / b_reg;
                    alu_b      = acc_reg % b_reg;
                    alu_ov     = 1'b0;
                    alu_acc_wr = 1'b1;
                    alu_b_wr   = 1'b1;
                end
            end
            default: begin
            end
        endcase
    end

    // ****************************************
    // boolean unit on the carry flag
    // ****************************************
    // carry is both source and destination
    always_comb begin
        case (bool_op)
            cpu_core_pkg::BOOL_CLR:  bool_cy = 1'b0;
            cpu_core_pkg::BOOL_SET:  bool_cy = 1'b1;
            cpu_core_pkg::BOOL_CPL:  bool_cy = ~psw_reg[`PSW_CARRY];
            cpu_core_pkg::BOOL_ANL:  bool_cy = psw_reg[`PSW_CARRY] & bool_bit;
            cpu_core_pkg::BOOL_ORL:  bool_cy = psw_reg[`PSW_CARRY] | bool_bit;
            cpu_core_pkg::BOOL_ANLN: bool_cy = psw_reg[`PSW_CARRY] & ~bool_bit;
            cpu_core_pkg::BOOL_MOV:  bool_cy = bool_bit;
            default:                 bool_cy = psw_reg[`PSW_CARRY];
        endcase
    end

    // ****************************************
    // main operand and helper registers
    // ****************************************
    // register write or increment wins over arithmetic results
    always_comb begin
        acc_next = alu_acc_wr ? alu_acc : acc_reg;
        if (sfr_wr && at_addr(sfr_addr, `SFR_MAIN_OPERAND)) begin
            acc_next = sfr_wdata;
        end else if (sfr_inc && at_addr(sfr_addr, `SFR_MAIN_OPERAND)) begin
            acc_next = acc_reg + 8'h01;
        end
        b_next = alu_b_wr ? alu_b : b_reg;
        if (sfr_wr && at_addr(sfr_addr, `SFR_MUL_DIV_AUX)) begin
            b_next = sfr_wdata;
        end else if (sfr_inc && at_addr(sfr_addr, `SFR_MUL_DIV_AUX)) begin
            b_next = b_reg + 8'h01;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_reg <= `RST_MAIN_OPERAND;
            b_reg   <= `RST_MUL_DIV_AUX;
        end else if (clk_en) begin
            acc_reg <= acc_next;
            b_reg   <= b_next;
        end
    end

    // parity tracks the operand value it will hold
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            parity_reg <= 1'b0;
        end else if (clk_en) begin
            parity_reg <= ^acc_next;
        end
    end

    // ****************************************
    // status word
    // ****************************************
    // parity bit is never stored from a write
    always_comb begin
        psw_next = psw_reg;
        if (alu_op != cpu_core_pkg::ALU_NONE) begin
            psw_next[`PSW_CARRY]       = alu_cy;
            psw_next[`PSW_SIGNED_WRAP] = alu_ov;
            if (alu_ac_wr) begin
                psw_next[`PSW_HALF_CARRY] = alu_ac;
            end
        end else if (bool_op != cpu_core_pkg::BOOL_NONE) begin
            psw_next[`PSW_CARRY] = bool_cy;
        end
        if (sfr_wr && at_addr(sfr_addr, `SFR_STATUS_WORD)) begin
            psw_next = sfr_wdata;
        end else if (sfr_inc && at_addr(sfr_addr, `SFR_STATUS_WORD)) begin
            psw_next = psw_view + 8'h01;
        end
        psw_next[`PSW_PARITY] = 1'b0;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            psw_reg <= `RST_STATUS_WORD;
        end else if (clk_en) begin
            psw_reg <= psw_next;
        end
    end

    // status word as software sees it
    always_comb begin
        psw_view              = psw_reg;
        psw_view[`PSW_PARITY] = parity_reg;
    end

    // ****************************************
    // stack pointer
    // ****************************************
    // push pre-increments, pop post-decrements, 8-bit wrap
    always_comb begin
        sp_next = sp_reg;
        if (sfr_wr && at_addr(sfr_addr, `SFR_STACK_POINTER)) begin
            sp_next = sfr_wdata;
        end else if (sfr_inc && at_addr(sfr_addr, `SFR_STACK_POINTER)) begin
            sp_next = sp_reg + 8'h01;
        end else if (push_req) begin
            sp_next = sp_reg + 8'h01;
        end else if (pop_req) begin
            sp_next = sp_reg - 8'h01;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sp_reg <= `RST_STACK_POINTER;
        end else if (clk_en) begin
            sp_reg <= sp_next;
        end
    end

    // ram request for push writes and pop reads
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ram_wr_en <= 1'b0;
            ram_addr  <= 8'h00;
            ram_wdata <= 8'h00;
        end else if (clk_en) begin
            ram_wr_en <= push_req && !((sfr_wr || sfr_inc) && at_addr(sfr_addr, `SFR_STACK_POINTER));
            if (push_req) begin
                ram_addr  <= sp_reg + 8'h01;
                ram_wdata <= push_data;
            end else if (pop_req) begin
                ram_addr <= sp_reg;
            end
        end
    end

    // ****************************************
    // dual data pointer
    // ****************************************
    // byte and word access routed to the selected pointer
    assign pb.aux_wr     = sfr_wr && at_addr(sfr_addr, `SFR_POINTER_AUX);
    assign pb.aux_toggle = sfr_inc && at_addr(sfr_addr, `SFR_POINTER_AUX);
    assign pb.aux_wdata  = sfr_wdata;
    assign pb.lo_wr      = sfr_wr && at_addr(sfr_addr, `SFR_POINTER_LOW);
    assign pb.hi_wr      = sfr_wr && at_addr(sfr_addr, `SFR_POINTER_HIGH);
    assign pb.byte_wdata = sfr_wdata;
    assign pb.load16     = ptr_load;
    assign pb.inc16      = ptr_inc;
    assign pb.load_val   = ptr_load_val;

    data_pointer_bank #(
        .NUM_PTR (2)
    ) u_ptr_bank (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .pb      (pb)
    );

    // ****************************************
    // register read port
    // ****************************************
    // unmapped addresses read zero with no hit
    always_comb begin
        rd_mapped = 1'b1;
        case (sfr_addr)
            `SFR_STACK_POINTER: rd_value = sp_reg;
            `SFR_POINTER_LOW:   rd_value = pb.lo;
            `SFR_POINTER_HIGH:  rd_value = pb.hi;
            `SFR_POINTER_AUX:   rd_value = pb.aux_rd;
            `SFR_STATUS_WORD:   rd_value = psw_view;
            `SFR_MAIN_OPERAND:  rd_value = acc_reg;
            `SFR_MUL_DIV_AUX:   rd_value = b_reg;
            default: begin
                rd_value  = 8'h00;
                rd_mapped = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sfr_rdata <= 8'h00;
            sfr_hit   <= 1'b0;
        end else if (clk_en) begin
            sfr_rdata <= sfr_rd ? rd_value : 8'h00;
            sfr_hit   <= sfr_rd && rd_mapped;
        end
    end

    // ****************************************
    // registered state outputs
    // ****************************************
    // mirrors carry next values so they match the registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stack_pointer    <= `RST_STACK_POINTER;
            cpu_status_word  <= `RST_STATUS_WORD;
            main_operand_reg <= `RST_MAIN_OPERAND;
            mul_div_aux      <= `RST_MUL_DIV_AUX;
            bank_base        <= 5'h00;
        end else if (clk_en) begin
            stack_pointer    <= sp_next;
            cpu_status_word  <= {psw_next[7:1], ^acc_next};
            main_operand_reg <= acc_next;
            mul_div_aux      <= b_next;
            bank_base        <= {psw_next[`PSW_BANK_HIGH],
                                 psw_next[`PSW_BANK_LOW], 3'h0};
        end
    end

    assign data_pointer_pair = pb.ptr_active;

endmodule

// [verification/core_regs_assertions.sv]
// ********
// port checks for the core registers
// ********
module core_regs_checker (
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic       sfr_inc,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic       push_req,
    input wire logic       ram_wr_en,
    input wire logic [7:0] ram_addr,
    input wire logic [7:0] stack_pointer,
    input wire logic [7:0] cpu_status_word,
    input wire logic [7:0] main_operand_reg,
    input wire logic [4:0] bank_base
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    // push accepted when software leaves the stack pointer alone
    sequence push_taken;
        push_req && !((sfr_wr || sfr_inc) && sfr_addr == 8'h81);
    endsequence
    a_push_slot: assert property (push_taken |=> ram_wr_en && ram_addr == stack_pointer)
        else $error("push slot");
    a_sp_step: assert property (push_taken |=>
        stack_pointer == $past(stack_pointer) + 8'h01) else $error("sp step");
    a_idle_no_write: assert property (!push_req |=> !ram_wr_en) else $error("stray write");
    a_sp_reset_value: assert property ($rose(rst_n) |-> stack_pointer == 8'h07) else $error("sp reset");
    a_parity_tracks: assert property (cpu_status_word[0] == ^main_operand_reg) else $error("parity");
    a_bank_map: assert property ($stable(cpu_status_word) |->
        bank_base == {cpu_status_word[4:3], 3'h0}) else $error("bank base");
    a_acc_write_lands: assert property (sfr_wr && sfr_addr == 8'hE0 |=>
        main_operand_reg == $past(sfr_wdata)) else $error("acc write");
    a_aux_spare_zero: assert property (sfr_rd && sfr_addr == 8'hA2 |=>
        (sfr_rdata & 8'hF6) == 8'h00) else $error("aux spare bits");
endmodule

bind cpu_core_status_and_pointers core_regs_checker core_regs_checker_inst (.ref_clk, .rst_n, .sfr_addr, .sfr_wr,
    .sfr_inc, .sfr_rd, .sfr_wdata, .sfr_rdata, .push_req, .ram_wr_en, .ram_addr, .stack_pointer, .cpu_status_word,
    .main_operand_reg, .bank_base);

// [verification/tb_top.sv]
// ********
// register-level bench for the core registers
// ********
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, rst_n = 1'b0, sfr_wr = 1'b0, sfr_inc = 1'b0, sfr_rd = 1'b0, bool_bit = 1'b0;
    logic push_req = 1'b0, pop_req = 1'b0, ptr_load = 1'b0, ptr_inc = 1'b0, ram_wr_en, sfr_hit;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, alu_operand = 8'h00, push_data = 8'h00;
    logic [7:0] sfr_rdata, ram_addr, cpu_status_word, main_operand_reg, ram_wdata, mul_div_aux;
    logic [15:0] ptr_load_val = 16'h0000, data_pointer_pair;
    logic [3:0] bool_steps [7] = '{4'h4, 4'hC, 4'h6, 4'hB, 4'h8, 4'hF, 4'h2};
    logic [6:0] cy_seq = 7'b1101010;
    cpu_core_pkg::alu_op_e alu_op = cpu_core_pkg::ALU_NONE;
    cpu_core_pkg::bool_op_e bool_op = cpu_core_pkg::BOOL_NONE;
    int fail_count = 0, cmp_count = 0;
    // device with enable held on
    cpu_core_status_and_pointers cpu_core_status_and_pointers_inst (.ref_clk, .rst_n, .clk_en(1'b1),
        .sfr_addr, .sfr_wr, .sfr_inc, .sfr_wdata, .sfr_rd, .sfr_rdata, .sfr_hit, .alu_op, .alu_operand, .bool_op,
        .bool_bit, .push_req, .push_data, .pop_req, .ptr_load, .ptr_load_val, .ptr_inc, .ram_wr_en, .ram_addr,
        .ram_wdata, .stack_pointer(), .cpu_status_word, .main_operand_reg, .mul_div_aux, .bank_base(),
        .data_pointer_pair);
    // 40 MHz clock
    initial forever #12.5 ref_clk = ~ref_clk;
    task automatic chk(input logic [15:0] seen, exp);
        cmp_count++;
        fail_count += int'(seen !== exp);
        if (seen !== exp) $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    endtask
    task automatic wr(input logic [7:0] a, d, input logic inc = 1'b0);
        @(posedge ref_clk) {sfr_addr, sfr_wdata, sfr_wr, sfr_inc} <= {a, d, !inc, inc};
        @(posedge ref_clk) {sfr_wr, sfr_inc} <= 2'b00;
    endtask
    task automatic rd(input logic [7:0] a, e);
        @(posedge ref_clk) {sfr_addr, sfr_rd} <= {a, 1'b1};
        @(posedge ref_clk) sfr_rd <= 1'b0;
        #1 chk({sfr_hit, 7'h00, sfr_rdata}, {1'b1, 7'h00, e});
    endtask
    task automatic go(input logic [2:0] o, b, input logic [7:0] x, input logic [15:0] e);
        @(posedge ref_clk) alu_op <= cpu_core_pkg::alu_op_e'(o);
        bool_op <= cpu_core_pkg::bool_op_e'(b);
        {alu_operand, bool_bit} <= {x, x[0]};
        @(posedge ref_clk) alu_op <= cpu_core_pkg::ALU_NONE;
        bool_op <= cpu_core_pkg::BOOL_NONE;
        #1 chk({main_operand_reg, cpu_status_word}, e);
    endtask
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // main sequence of register, arithmetic, pointer and stack steps
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(8'h81, 8'h07);
        rd(8'hD0, 8'h00);
        rd(8'hE0, 8'h00);
        rd(8'hA2, 8'h00);
        wr(8'hD0, 8'hFF);
        rd(8'hD0, 8'hFE);
        wr(8'hE0, 8'hFF);
        go(3'h1, 3'h0, 8'h01, 16'h00FA);
        go(3'h2, 3'h0, 8'h7F, 16'h807F);
        go(3'h3, 3'h0, 8'h80, 16'h003A);
        go(3'h3, 3'h0, 8'h01, 16'hFFFA);
        wr(8'hF0, 8'h02);
        go(3'h4, 3'h0, 8'h00, 16'hFE7F);
        chk({8'h00, mul_div_aux}, 16'h0001);
        rd(8'hF0, 8'h01);
        go(3'h5, 3'h0, 8'h00, 16'hFE7B);
        go(3'h5, 3'h0, 8'h00, 16'hFE7F);
        foreach (bool_steps[i]) begin
            go(3'h0, bool_steps[i][3:1], {7'h00, bool_steps[i][0]}, {8'hFE, cy_seq[6-i], 7'h7F});
        end
        wr(8'h82, 8'h34);
        wr(8'h83, 8'h12);
        rd(8'h83, 8'h12);
        wr(8'hA2, 8'h00, 1'b1);
        rd(8'hA2, 8'h01);
        rd(8'h83, 8'h00);
        @(posedge ref_clk) {ptr_load, ptr_load_val} <= {1'b1, 16'hABCD};
        @(posedge ref_clk) {ptr_load, ptr_inc} <= 2'b01;
        @(posedge ref_clk) ptr_inc <= 1'b0;
        #1 chk(data_pointer_pair, 16'hABCE);
        rd(8'h82, 8'hCE);
        wr(8'hA2, 8'hFF);
        rd(8'hA2, 8'h09);
        wr(8'hA2, 8'hF6);
        #1 chk(data_pointer_pair, 16'h1234);
        rd(8'h82, 8'h34);
        wr(8'h81, 8'hFE);
        @(posedge ref_clk) {push_req, push_data} <= {1'b1, 8'hAA};
        @(posedge ref_clk) push_data <= 8'hBB;
        @(posedge ref_clk) push_req <= 1'b0;
        #1 chk({7'h00, ram_wr_en, ram_addr}, 16'h0100);
        chk({ram_wdata, ram_addr}, 16'hBB00);
        rd(8'h81, 8'h00);
        @(posedge ref_clk) pop_req <= 1'b1;
        @(posedge ref_clk) pop_req <= 1'b0;
        #1 chk({7'h00, ram_wr_en, ram_addr}, 16'h0000);
        rd(8'h81, 8'hFF);
        tally_and_finish();
    end
endmodule
